// *** rtl/codec_control_port.sv ***
// Codec serial control port with its sixteen-entry register file
//
// Behaviour
// - Sixteen registers reached only via the control port, sixteen bits per frame.
// - Active-low frame latch gates clock and data lines.
// - Serial clock samples input bits and shifts readback bits out.
// - Each control word passes through a sixteen-bit shift register.
// - Bits 15..12 select one of sixteen registers.
// - Bit 11 chooses direction: zero writes, one reads.
// - Bit 10 reserved; bits 9..0 carry register data.
// - Data output forwards input bits sixteen bits late; only frames of exactly sixteen bits are captured.
// - Data output released while latch is high; clock and data ignored.
// - Data interface offers DSP and I2S modes, DSP after reset; this module only outputs the format fields, zero after reset.
// - DSP mode also carries control words on the data interface; this module only outputs the mixed-mode bit.
// - Data interface can be master or slave in either mode; this module only outputs the master/slave bit.
// - DSP frame has fixed sample and control slots with separate sync; no data-interface framing is built here.
// - I2S samples go MSB first around left/right clock toggles; no I2S data logic is built here.
// - Left ADC address writes gain, reads return ten-bit peak level.
// - Power register layout with software reset at bit 9.
// - Serial control layout: TDM enable, slot, formats, mixed, master.
// - Mute register layout with word widths, mutes and reserved bits.
// - ADC configuration layout with peak select and loopbacks.
// - Trim register layout: fuse blow, link trim, software trim.
// - Data port uses only its programmed slot after frame sync; this module only outputs the slot field.
// - Software reset bit returns registers to the reset state.
`timescale 1ns/10ps
module codec_control_port
   import codec_ctl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ctl_serial_clk,
   input wire logic i_ctl_frame_n,
   input wire logic i_ctl_sdi,
   output logic o_ctl_sdo,
   output logic o_ctl_sdo_oe,
   input wire logic [DATA_BITS-1:0] i_left_adc_peak,
   input wire logic [DATA_BITS-1:0] i_right_adc_peak,
   output logic [DATA_BITS-1:0] o_power_settings,
   output logic [DATA_BITS-1:0] o_clock_dividers,
   output serial_cfg_t o_serial_cfg,
   output logic [DATA_BITS-1:0] o_mute_and_width,
   output logic [DATA_BITS-1:0] o_input_output_config,
   output logic [DATA_BITS-1:0] o_left_adc_gain,
   output logic [DATA_BITS-1:0] o_right_adc_gain,
   output logic [DATA_BITS-1:0] o_filter_select,
   output logic [DATA_BITS-1:0] o_left_dac_atten,
   output logic [DATA_BITS-1:0] o_right_dac_gain,
   output logic [DATA_BITS-1:0] o_reference_trim,
   output logic [DATA_BITS-1:0] o_test_mode_control
);

   ////////////////////////////////////////////////////////////////////////
   // Link domain: runs on the host serial clock, only while a frame is open

   // System-side state is declared here because the link side reads it
   sys_state_t sy;
   sys_state_t next_sy;
   link_state_t lk;
   link_state_t next_lk;
   frame_cap_t cap;
   logic [FRAME_BITS-1:0] rd_frame;
   logic rd_tog_link;

   // Readback word is stable long before the next frame starts, so a
   // plain sample at frame start is safe; toggle still crosses by flops.
   logic [SYNC_STAGES-1:0] rd_tog_sync;

   // Readback leaves as a full sixteen-bit word, upper bits zero
   assign rd_frame = {{(FRAME_BITS-DATA_BITS){1'b0}}, sy.readback};

   always_comb begin
      next_lk = lk;
      if (!i_ctl_frame_n) begin
         next_lk.shift = {lk.shift[FRAME_BITS-2:0], i_ctl_sdi};
         if (lk.count != CNT_BITS'(FRAME_BITS + 1)) begin
            next_lk.count = lk.count + CNT_BITS'(1);
         end
         if (lk.count == '0) begin
            // First edge: MSB goes straight out so the host sees it on bit one
            next_lk.sdo = rd_frame[FRAME_BITS-1];
            next_lk.out_shift = {rd_frame[FRAME_BITS-2:0], i_ctl_sdi};
         end else begin
            // Readback bits first, then forwarded input for chaining
            next_lk.sdo = lk.out_shift[FRAME_BITS-1];
            next_lk.out_shift = {lk.out_shift[FRAME_BITS-2:0], i_ctl_sdi};
         end
      end
   end

   // Frame counter and output shifter must restart each frame; the frame
   // edge itself is the only event available while the serial clock idles.
   always_ff @(posedge i_ctl_serial_clk or posedge i_ctl_frame_n) begin
      if (i_ctl_frame_n) begin
         lk <= '0;
      end else begin
         lk <= next_lk;
      end
   end

   // Completed frame captured at the latch's rising edge; the counter still
   // holds its old value here because its own reset lands as a late update
   always_ff @(posedge i_ctl_frame_n or posedge i_rst) begin
      if (i_rst) begin
         cap <= '0;
      end else if (lk.count == CNT_BITS'(FRAME_BITS)) begin
         cap.toggle <= ~cap.toggle;
         cap.word <= lk.shift;
      end
   end

   always_ff @(negedge i_ctl_frame_n) begin
      rd_tog_sync <= {rd_tog_sync[SYNC_STAGES-2:0], sy.read_toggle};
   end
   assign rd_tog_link = rd_tog_sync[SYNC_STAGES-1];

   assign o_ctl_sdo = lk.sdo;
   assign o_ctl_sdo_oe = ~i_ctl_frame_n;

   ////////////////////////////////////////////////////////////////////////
   // System domain: register file

   logic frame_event;
   logic [FRAME_BITS-1:0] word;
   logic [ADDR_BITS-1:0] addr;
   logic [DATA_BITS-1:0] wmask;

   assign frame_event = (sy.tog_sync[2] == sy.tog_sync[1]) && (sy.tog_sync[2] != sy.tog_seen);
   assign word = cap.word;
   assign addr = word[ADDR_MSB:ADDR_LSB];

   always_comb begin
      unique case (addr)
         REG_POWER_SETTINGS, REG_SERIAL_PORT_CONTROL, REG_FILTER_SELECT,
         REG_LEFT_DAC_GAIN, REG_RIGHT_DAC_GAIN, REG_REFERENCE_TRIM,
         REG_TEST_MODE_CONTROL: wmask = MASK_FULL;
         REG_CLOCK_DIVIDERS: wmask = MASK_CLOCK_DIVIDERS;
         REG_MUTE_AND_WIDTH: wmask = MASK_MUTE_AND_WIDTH;
         REG_INPUT_OUTPUT_CONFIG: wmask = MASK_INPUT_OUTPUT_CONFIG;
         REG_LEFT_ADC_GAIN_PEAK, REG_RIGHT_ADC_GAIN_PEAK: wmask = MASK_ADC_GAIN;
         default: wmask = '0;
      endcase
   end

   always_comb begin
      next_sy = sy;
      next_sy.tog_sync = {sy.tog_sync[1:0], cap.toggle};
      if (frame_event) begin
         next_sy.tog_seen = sy.tog_sync[2];
         if (!word[DIR_BIT]) begin
            next_sy.regs[addr] = word[DATA_MSB:0] & wmask;
            if (addr == REG_POWER_SETTINGS && word[SOFT_RESET_BIT]) begin
               next_sy.regs = '0;
            end
         end else begin
            next_sy.read_toggle = ~sy.read_toggle;
            if (addr == REG_LEFT_ADC_GAIN_PEAK) begin
               next_sy.readback = i_left_adc_peak;
            end else if (addr == REG_RIGHT_ADC_GAIN_PEAK) begin
               next_sy.readback = i_right_adc_peak;
            end else begin
               next_sy.readback = sy.regs[addr];
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sy <= '0;
      end else begin
         sy <= next_sy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register fields out to the data interface and analog sections

   assign o_power_settings = sy.regs[REG_POWER_SETTINGS];
   assign o_clock_dividers = sy.regs[REG_CLOCK_DIVIDERS];
   // Zero mode bits select DSP slave mode after reset
   // Data-interface framing and slot logic lives outside; it only sees these fields
   assign o_serial_cfg = serial_cfg_t'(sy.regs[REG_SERIAL_PORT_CONTROL]);
   assign o_mute_and_width = sy.regs[REG_MUTE_AND_WIDTH];
   assign o_input_output_config = sy.regs[REG_INPUT_OUTPUT_CONFIG];
   assign o_left_adc_gain = sy.regs[REG_LEFT_ADC_GAIN_PEAK];
   assign o_right_adc_gain = sy.regs[REG_RIGHT_ADC_GAIN_PEAK];
   assign o_filter_select = sy.regs[REG_FILTER_SELECT];
   assign o_left_dac_atten = sy.regs[REG_LEFT_DAC_GAIN];
   assign o_right_dac_gain = sy.regs[REG_RIGHT_DAC_GAIN];
   assign o_reference_trim = sy.regs[REG_REFERENCE_TRIM];
   assign o_test_mode_control = sy.regs[REG_TEST_MODE_CONTROL];

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // System-clock checks on the register file and the data output line

   AST_RESERVED_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      sy.regs[REG_CLOCK_DIVIDERS][9:6] == 4'h0 && sy.regs[4'h7] == '0)
      else $error("Reserved register bits not zero");

   AST_SOFT_RESET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && !word[DIR_BIT] && addr == REG_POWER_SETTINGS && word[SOFT_RESET_BIT]
      |=> sy.regs == '0)
      else $error("Software reset left a register set");

   AST_WRITE_LANDS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && !word[DIR_BIT] && addr == REG_REFERENCE_TRIM
      |=> o_reference_trim == $past(word[DATA_MSB:0]))
      else $error("Write did not land");

   AST_READ_HOLDS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && word[DIR_BIT] |=> sy.regs == $past(sy.regs))
      else $error("Read changed registers");

   AST_PEAK_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && word[DIR_BIT] && addr == REG_LEFT_ADC_GAIN_PEAK
      |=> sy.readback == $past(i_left_adc_peak))
      else $error("Peak readback wrong");

   AST_NO_EVENT_STILL: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !frame_event |=> sy.regs == $past(sy.regs))
      else $error("Register changed without frame");

   // Line is released and parked low as soon as the latch rises
   AST_SDO_RELEASE: assert property (@(posedge i_clk_sys)
      i_ctl_frame_n |-> !o_ctl_sdo_oe && !o_ctl_sdo)
      else $error("Output driven outside frame");

   AST_MUTE_MASK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_mute_and_width[3:2] == 2'b00)
      else $error("Mute reserved bits set");

   AST_RIGHT_PEAK_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && word[DIR_BIT] && addr == REG_RIGHT_ADC_GAIN_PEAK
      |=> sy.readback == $past(i_right_adc_peak))
      else $error("Right peak readback wrong");

   AST_REG_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && word[DIR_BIT] && addr != REG_LEFT_ADC_GAIN_PEAK
      && addr != REG_RIGHT_ADC_GAIN_PEAK
      |=> sy.readback == $past(sy.regs[addr]))
      else $error("Register readback wrong");

   AST_READ_TOGGLES: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && word[DIR_BIT] |=> sy.read_toggle != $past(sy.read_toggle))
      else $error("Read did not flag new readback");

   AST_WRITE_NO_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && !word[DIR_BIT] |=> $stable(sy.readback) && $stable(sy.read_toggle))
      else $error("Write disturbed readback");

   AST_GAIN_MASK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_left_adc_gain[9:2] == 8'h00 && o_right_adc_gain[9:2] == 8'h00)
      else $error("Gain reserved bits set");

   AST_IO_MASK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_input_output_config[8] == 1'b0)
      else $error("Input config reserved bit set");

   AST_RSVD_REGS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      sy.regs[4'h8] == '0 && sy.regs[4'hc] == '0 && sy.regs[4'hd] == '0)
      else $error("Reserved register holds data");

   // Zero serial config means DSP format, slave, no slot multiplexing
   AST_RESET_DEFAULT: assert property (@(posedge i_clk_sys)
      i_rst |=> sy.regs == '0 && o_serial_cfg == '0)
      else $error("Reset left a register set");

   AST_SINGLE_EVENT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event |=> !frame_event)
      else $error("One frame applied twice");

   AST_SEEN_FOLLOWS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event |=> sy.tog_seen == $past(sy.tog_sync[2]))
      else $error("Frame event not retired");

   AST_OE_IN_FRAME: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_ctl_frame_n |-> o_ctl_sdo_oe)
      else $error("Output not driven inside frame");

   // Mixed mode lets control words share the data frame
   AST_SPC_FIELDS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_serial_cfg.tdm_enable == sy.regs[REG_SERIAL_PORT_CONTROL][SPC_TDM_EN]
      && o_serial_cfg.slot_position == sy.regs[REG_SERIAL_PORT_CONTROL][SPC_SLOT_MSB:SPC_SLOT_LSB]
      && o_serial_cfg.mixed_mode_en == sy.regs[REG_SERIAL_PORT_CONTROL][SPC_MIXED]
      && o_serial_cfg.master_slave_sel == sy.regs[REG_SERIAL_PORT_CONTROL][SPC_MASTER])
      else $error("Serial config fields misplaced");

   AST_CLKDIV_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && !word[DIR_BIT] && addr == REG_CLOCK_DIVIDERS
      |=> o_clock_dividers == ($past(word[DATA_MSB:0]) & MASK_CLOCK_DIVIDERS))
      else $error("Clock divider write wrong");

   AST_MUTE_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && !word[DIR_BIT] && addr == REG_MUTE_AND_WIDTH
      |=> o_mute_and_width == ($past(word[DATA_MSB:0]) & MASK_MUTE_AND_WIDTH))
      else $error("Mute write wrong");

   AST_GAIN_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && !word[DIR_BIT] && addr == REG_LEFT_ADC_GAIN_PEAK
      |=> o_left_adc_gain == ($past(word[DATA_MSB:0]) & MASK_ADC_GAIN))
      else $error("Gain write wrong");

   AST_DAC_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && !word[DIR_BIT] && addr == REG_LEFT_DAC_GAIN
      |=> o_left_dac_atten == $past(word[DATA_MSB:0]))
      else $error("DAC gain write wrong");

   AST_OTHERS_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      frame_event && !word[DIR_BIT] && addr == REG_REFERENCE_TRIM
      |=> o_test_mode_control == $past(o_test_mode_control))
      else $error("Write hit the wrong register");

   // Software reset never sticks, so the bit always reads back clear
   AST_SOFT_RESET_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_power_settings[SOFT_RESET_BIT] == 1'b0)
      else $error("Software reset bit stuck");

   ////////////////////////////////////////////////////////////////////////
   // Link-clock checks, off while the latch is high

   AST_COUNT_LIMIT: assert property (@(posedge i_ctl_serial_clk)
      disable iff (i_ctl_frame_n)
      lk.count <= CNT_BITS'(FRAME_BITS + 1))
      else $error("Bit counter overran");

   AST_SHIFT_IN: assert property (@(posedge i_ctl_serial_clk)
      disable iff (i_ctl_frame_n)
      lk.count != '0 |-> lk.shift[0] == $past(i_ctl_sdi))
      else $error("Input bit not shifted in");

   AST_CHAIN_IN: assert property (@(posedge i_ctl_serial_clk)
      disable iff (i_ctl_frame_n)
      lk.count != '0 |-> lk.out_shift[0] == $past(i_ctl_sdi))
      else $error("Input bit not queued for forwarding");

   // Seventh bit out is the top data bit of the readback word
   AST_SDO_DATA_MSB: assert property (@(posedge i_ctl_serial_clk)
      disable iff (i_ctl_frame_n)
      lk.count == CNT_BITS'(FRAME_BITS - DATA_BITS + 1)
      |-> o_ctl_sdo == sy.readback[DATA_BITS-1])
      else $error("Readback MSB misplaced");
endmodule

// *** rtl/codec_ctl_pkg.sv ***
// Package: register map, field layouts and control-word layout of the codec control port
package codec_ctl_pkg;
   localparam int FRAME_BITS = 16;
   localparam int DATA_BITS = 10;
   localparam int ADDR_BITS = 4;
   localparam int NUM_REGS = 16;
   localparam int CNT_BITS = 5;
   // Control word field positions
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int DIR_BIT = 11;
   localparam int RSVD_BIT = 10;
   localparam int DATA_MSB = 9;
   // Register offsets
   localparam logic [3:0] REG_POWER_SETTINGS = 4'h0;
   localparam logic [3:0] REG_CLOCK_DIVIDERS = 4'h1;
   localparam logic [3:0] REG_SERIAL_PORT_CONTROL = 4'h2;
   localparam logic [3:0] REG_MUTE_AND_WIDTH = 4'h3;
   localparam logic [3:0] REG_INPUT_OUTPUT_CONFIG = 4'h4;
   localparam logic [3:0] REG_LEFT_ADC_GAIN_PEAK = 4'h5;
   localparam logic [3:0] REG_RIGHT_ADC_GAIN_PEAK = 4'h6;
   localparam logic [3:0] REG_FILTER_SELECT = 4'h9;
   localparam logic [3:0] REG_LEFT_DAC_GAIN = 4'ha;
   localparam logic [3:0] REG_RIGHT_DAC_GAIN = 4'hb;
   localparam logic [3:0] REG_REFERENCE_TRIM = 4'he;
   localparam logic [3:0] REG_TEST_MODE_CONTROL = 4'hf;
   // Writable bit masks per register (reserved bits clear)
   localparam logic [9:0] MASK_FULL = 10'h3ff;
   localparam logic [9:0] MASK_CLOCK_DIVIDERS = 10'h03f;
   localparam logic [9:0] MASK_MUTE_AND_WIDTH = 10'h3f3;
   localparam logic [9:0] MASK_INPUT_OUTPUT_CONFIG = 10'h2ff;
   localparam logic [9:0] MASK_ADC_GAIN = 10'h003;
   // Reset values
   localparam logic [9:0] RESET_VALUE = 10'h000;
   localparam int SOFT_RESET_BIT = 9;
   // Serial port control fields
   localparam int SPC_TDM_EN = 9;
   localparam int SPC_SLOT_MSB = 8;
   localparam int SPC_SLOT_LSB = 6;
   localparam int SPC_MIXED = 1;
   localparam int SPC_MASTER = 0;
   localparam int SYNC_STAGES = 3;

   typedef logic [DATA_BITS-1:0] reg_word_t;

   typedef struct packed {
      logic [FRAME_BITS-1:0] shift;
      logic [CNT_BITS-1:0] count;
      logic [FRAME_BITS-1:0] out_shift;
      logic sdo;
   } link_state_t;

   // Completed frame, captured on the latch edge and handed to the system side
   typedef struct packed {
      logic toggle;
      logic [FRAME_BITS-1:0] word;
   } frame_cap_t;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] tog_sync;
      logic tog_seen;
      logic [NUM_REGS-1:0][DATA_BITS-1:0] regs;
      logic [DATA_BITS-1:0] readback;
      logic read_toggle;
   } sys_state_t;

   typedef struct packed {
      logic tdm_enable;
      logic [2:0] slot_position;
      logic [1:0] dac_format;
      logic [1:0] adc_format;
      logic mixed_mode_en;
      logic master_slave_sel;
   } serial_cfg_t;
endpackage

// *** verification/host_port_model.sv ***
// Host serial port model that drives frames into the codec control port
`timescale 1ns/10ps
module host_port_model (
   output logic o_sclk,
   output logic o_frame_n,
   output logic o_sdi,
   input wire logic i_sdo
);
   // Late rising latch edge so the link side surely clears at start-up
   initial begin
      o_sclk = 1'b0;
      o_frame_n = 1'b0;
      o_sdi = 1'b0;
      #1 o_frame_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Clock stands still between frames; data shows the inverse once released
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rx);
      rx = '0;
      o_frame_n = 1'b0;
      #16;
      for (int i = 0; i < nbits; i++) begin
         o_sdi = w[15 - (i % 16)];
         #16 o_sclk = 1'b1;
         #16 o_sclk = 1'b0;
         rx = {rx[14:0], i_sdo};
      end
      #16 o_frame_n = 1'b1;
      o_sdi = ~o_sdi;
   endtask
endmodule

// *** verification/tb.sv ***
// Self-checking testbench for the codec control port
`timescale 1ns/10ps
module tb;
   import codec_ctl_pkg::*;
   logic i_clk_sys, i_rst, sclk, frame_n, sdi, sdo, sdo_oe;
   logic [9:0] lpeak, rpeak, o_pwr, o_clkd, o_mute, o_io, o_lg, o_rg, o_flt, o_ld, o_rd;
   logic [9:0] o_trim, o_test;
   serial_cfg_t cfg;
   logic [15:0][9:0] obs;
   logic [9:0] shadow [16];
   logic [15:0] rx;
   int error_cnt, checked;

   assign obs = {o_test, o_trim, 20'h0_0000, o_rd, o_ld, o_flt, 20'h0_0000, o_rg, o_lg,
      o_io, o_mute, 10'(cfg), o_clkd, o_pwr};

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   codec_control_port dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ctl_serial_clk(sclk),
      .i_ctl_frame_n(frame_n), .i_ctl_sdi(sdi), .o_ctl_sdo(sdo), .o_ctl_sdo_oe(sdo_oe),
      .i_left_adc_peak(lpeak), .i_right_adc_peak(rpeak), .o_power_settings(o_pwr),
      .o_clock_dividers(o_clkd), .o_serial_cfg(cfg), .o_mute_and_width(o_mute),
      .o_input_output_config(o_io), .o_left_adc_gain(o_lg), .o_right_adc_gain(o_rg),
      .o_filter_select(o_flt), .o_left_dac_atten(o_ld), .o_right_dac_gain(o_rd),
      .o_reference_trim(o_trim), .o_test_mode_control(o_test));

   host_port_model host_u (.o_sclk(sclk), .o_frame_n(frame_n), .o_sdi(sdi), .i_sdo(sdo));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [9:0] mask_of(input logic [3:0] a);
      case (a)
         4'h1: return MASK_CLOCK_DIVIDERS;
         4'h3: return MASK_MUTE_AND_WIDTH;
         4'h4: return MASK_INPUT_OUTPUT_CONFIG;
         4'h5, 4'h6: return MASK_ADC_GAIN;
         4'h7, 4'h8, 4'hc, 4'hd: return 10'h000;
         default: return MASK_FULL;
      endcase
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Six system clocks covers the 3-4 cycle crossing plus the frame gap
   task automatic wr(input logic [15:0] w, input int n);
      @(negedge i_clk_sys);
      host_u.xfer(w, n, rx);
      repeat (6) @(negedge i_clk_sys);
   endtask

   task automatic check_all();
      for (int a = 0; a < 16; a++) chk(16'(obs[a]), 16'(shadow[a]));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #600000;
      error_cnt++;
      stop_test();
   end

   initial begin
      int unused;
      logic [3:0] a;
      logic [9:0] d;
      unused = $urandom(43);
      // Reset rises after time zero so the latch-side capture sees its edge
      i_rst = 1'b0;
      #2 i_rst = 1'b1;
      lpeak = '0;
      rpeak = '0;
      error_cnt = 0;
      checked = 0;
      for (int i = 0; i < 16; i++) shadow[i] = '0;
      repeat (8) @(negedge i_clk_sys);
      i_rst = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      check_all();
      chk(16'(sdo_oe), 16'h0000);
      // Every address once, then random ones
      for (int i = 0; i < 48; i++) begin
         a = (i < 16) ? 4'(i) : 4'($urandom);
         d = 10'($urandom);
         if (a == 4'h0) d[9] = 1'b0;
         wr({a, 2'b00, d}, 16);
         shadow[a] = d & mask_of(a);
         check_all();
         if (a == 4'h2) chk(16'(cfg.slot_position), 16'(d[8:6]));
      end
      wr({4'h3, 2'b00, 10'h155}, 15);
      check_all();
      wr({4'h9, 2'b00, 10'h2aa}, 17);
      check_all();
      // Readback comes out during the following harmless frame
      for (int i = 0; i < 16; i++) begin
         a = 4'(i);
         lpeak = 10'($urandom);
         rpeak = 10'($urandom);
         wr({a, 1'b1, 11'h000}, 16);
         wr({4'h7, 12'h000}, 16);
         d = (a == 4'h5) ? lpeak : (a == 4'h6) ? rpeak : shadow[a];
         chk(rx, {6'h00, d});
      end
      check_all();
      wr({4'h0, 2'b00, 10'h200}, 16);
      for (int i = 0; i < 16; i++) shadow[i] = '0;
      check_all();
      stop_test();
   end
endmodule
